// *** include/cmp_event_map.svh ***
// register offsets, field positions and reset values for the comparator event control block
// assumes a 32-bit avalon word bus, byte addresses, one register per aligned word
`ifndef CMP_EVENT_MAP_SVH
`define CMP_EVENT_MAP_SVH
`define OFS_CTRL1 6'h00
`define OFS_CTRL2 6'h04
`define OFS_CTRL3 6'h08
`define OFS_CTRL4 6'h0C
`define OFS_MSK1 6'h10
`define OFS_MSK2 6'h14
`define OFS_MSK3 6'h18
`define OFS_MSK4 6'h1C
`define OFS_STATUS 6'h20
`define OFS_IDLE 6'h24
`define BIT_ON 15
`define BIT_OE 14
`define BIT_INV 13
`define BIT_AMP 10
`define BIT_EVT 9
`define BIT_RES 8
`define BIT_REF 4
`define BIT_STOP 15
`define FLD_EDGE 7:6
`define FLD_NEG 1:0
`define FLD_MSK_A 3:0
`define FLD_MSK_B 7:4
`define FLD_MSK_C 11:8
`define CTRL_WMASK 16'hE6D3
`define CTRL4_WMASK 16'hE2D3
`define MSK_WMASK 16'h0FFF
`define STAT_EVT_LSB 8
`define REG_RESET 16'h0000
`define EDGE_NONE 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_ANY 2'h3
`define NEG_FIRST 2'h0
`define NEG_SECOND 2'h1
`define MSK_RESERVED_LO 4'h6
`define MSK_RESERVED_HI 4'hB
`define MSK_TRIG_BASE 4'hC
`define NUM_CMP 4
`endif

// *** include/cmp_event_pkg.sv ***
// types shared by the comparator event control block
// assumes cmp_event_map.svh is included alongside
package cmp_event_pkg;
  typedef struct packed {
    logic on;
    logic oe;
    logic inv;
    logic amp;
    logic ref_sel;
    logic [1:0] edge_sel;
    logic [1:0] neg_sel;
  } cmp_cfg_s;
  typedef struct packed {
    logic [5:0] pwm;
    logic [1:0] trig;
    logic fault_two;
    logic fault_four;
  } mask_src_s;
endpackage : cmp_event_pkg

// *** rtl/cmp_event_ctrl.sv ***
// digital control and event logic for four analog comparators with mask source selection
// assumes raw comparator results are synchronous-capable levels; avalon master per system spec
// Operation
// - a comparator works only while its enable bit is set
// - output pin enable drives the result to the pin, else internal only
// - polarity bit inverts the comparator output, clear passes it unchanged
// - result reads 1 when plus exceeds minus, reversed under inversion
// - comparators one to three run as op amp when mode bit set
// - matching edge sets sticky event flag; flag blocks triggers until cleared
// - edge code 11 fires on any output change while flag clear
// - edge code 10 fires on falling adjusted output while flag clear
// - edge code 01 fires on rising adjusted output while flag clear
// - edge code 00 never fires
// - reference select routes plus input to internal reference, else first pin
// - negative code 00 first pin, 01 second pin, 10/11 unimplemented
// - op amp mode withholds internal reference and second negative pin
// - a selected input that does not exist is tied to ground
// - fourth comparator minus: own pin, comparator one, two or three
// - fourth comparator plus uses own pin when clear; no op amp bit
// - mask c field picks pwm, trigger or fault source; middle codes reserved
// - mask b field uses the same encoding
// - mask a field uses the same encoding
// - unimplemented bits read zero; implemented bits reset to zero
// - shared status mirrors each event flag and result bit
// - stop-in-idle halts all comparators while the device idles
//
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "cmp_event_map.svh"
module cmp_event_ctrl
  import cmp_event_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // system
  input wire logic device_idle,
  // analog cores
  input wire logic [3:0] raw_result,
  output logic [3:0] core_enable,
  output logic [2:0] amplifier_mode_select,
  output logic [3:0] plus_sel_reference,
  output logic [3:0] plus_sel_pin,
  output logic [2:0] minus_sel_first,
  output logic [2:0] minus_sel_second,
  output logic [3:0] minus_sel_fourth,
  output logic [3:0] compare_output_pin,
  // events
  output logic [3:0] event_trigger,
  output logic [3:0] event_irq,
  // blanking sources and selected masks per comparator
  input wire mask_src_s mask_sources,
  output logic [3:0] mask_a,
  output logic [3:0] mask_b,
  output logic [3:0] mask_c
);

  function automatic logic mask_pick(input mask_src_s s, input logic [3:0] code);
    logic v;
    v = 1'b0;
    if (code < `MSK_RESERVED_LO) v = s.pwm[code[2:0]];
    else if (code >= `MSK_TRIG_BASE) v = code[1] ? (code[0] ? s.fault_four : s.fault_two) : s.trig[code[0]];
    return v;
  endfunction : mask_pick

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be,
                                        input logic [15:0] wm);
    logic [15:0] n;
    n = old;
    if (be[0]) n[7:0] = wd[7:0];
    if (be[1]) n[15:8] = wd[15:8];
    return n & wm;
  endfunction : merge

  logic [15:0] ctrl_r [4];
  logic [15:0] msk_r [4];
  logic [3:0] evt_r;
  logic idle_stop_r;
  logic [3:0] s1_r, s2_r, prev_r;
  logic [31:0] rdata_r;
  logic rvalid_r;

  cmp_cfg_s cfg [4];
  logic [3:0] run, adj, adj_prev, fire, evt_clr;
  wire wr_go = avs_write & ~avs_waitrequest;
  wire rd_go = avs_read & ~avs_waitrequest;
  wire [3:0] word_idx = avs_address[5:2];

  // one wait cycle on reads gives registered read data; writes complete at once
  assign avs_waitrequest = avs_read & ~rvalid_r;
  assign avs_readdata = rdata_r;

  genvar g;
  generate
    for (g = 0; g < `NUM_CMP; g++) begin : gen_cmp
      assign cfg[g].on = ctrl_r[g][`BIT_ON];
      assign cfg[g].oe = ctrl_r[g][`BIT_OE];
      assign cfg[g].inv = ctrl_r[g][`BIT_INV];
      assign cfg[g].amp = (g < 3) ? ctrl_r[g][`BIT_AMP] : 1'b0;
      assign cfg[g].ref_sel = ctrl_r[g][`BIT_REF];
      assign cfg[g].edge_sel = ctrl_r[g][`FLD_EDGE];
      assign cfg[g].neg_sel = ctrl_r[g][`FLD_NEG];
      assign run[g] = cfg[g].on & ~(idle_stop_r & device_idle);
      assign core_enable[g] = run[g];
      // synchronised sample, polarity applied after the second flop
      assign adj[g] = (s2_r[g] ^ cfg[g].inv) & run[g];
      assign adj_prev[g] = prev_r[g];
      assign fire[g] = run[g] & ~evt_r[g] & (
        (cfg[g].edge_sel == `EDGE_ANY && adj[g] != adj_prev[g]) ||
        (cfg[g].edge_sel == `EDGE_FALL && !adj[g] && adj_prev[g]) ||
        (cfg[g].edge_sel == `EDGE_RISE && adj[g] && !adj_prev[g]));
      assign compare_output_pin[g] = cfg[g].oe & adj[g];
      // reference withheld in amp mode; missing input selects nothing, so the core grounds it
      assign plus_sel_reference[g] = cfg[g].ref_sel & ~cfg[g].amp;
      assign plus_sel_pin[g] = ~cfg[g].ref_sel;
      assign mask_a[g] = mask_pick(mask_sources, msk_r[g][`FLD_MSK_A]);
      assign mask_b[g] = mask_pick(mask_sources, msk_r[g][`FLD_MSK_B]);
      assign mask_c[g] = mask_pick(mask_sources, msk_r[g][`FLD_MSK_C]);
      assign evt_clr[g] = wr_go && word_idx == 4'(g) && avs_byteenable[1] && !avs_writedata[`BIT_EVT];
    end
    for (g = 0; g < 3; g++) begin : gen_amp
      assign amplifier_mode_select[g] = cfg[g].amp & run[g];
      assign minus_sel_first[g] = cfg[g].neg_sel == `NEG_FIRST;
      assign minus_sel_second[g] = cfg[g].neg_sel == `NEG_SECOND && !cfg[g].amp;
    end
  endgenerate

  // fourth comparator minus select one-hot: own pin, one, two, three
  assign minus_sel_fourth = 4'h1 << cfg[3].neg_sel;
  assign event_trigger = fire;
  assign event_irq = fire;

  wire [15:0] status_w = {idle_stop_r, 3'h0, evt_r, 4'h0, ctrl_r[3][`BIT_RES], ctrl_r[2][`BIT_RES],
                          ctrl_r[1][`BIT_RES], ctrl_r[0][`BIT_RES]};
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    unique case (avs_address)
      `OFS_CTRL1, `OFS_CTRL2, `OFS_CTRL3, `OFS_CTRL4: rd_mux = ctrl_r[word_idx[1:0]];
      `OFS_MSK1, `OFS_MSK2, `OFS_MSK3, `OFS_MSK4: rd_mux = msk_r[word_idx[1:0]];
      `OFS_STATUS: rd_mux = status_w;
      `OFS_IDLE: rd_mux = {15'h0000, idle_stop_r};
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      rvalid_r <= avs_read & ~rvalid_r;
      rdata_r <= {16'h0000, rd_mux};
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
      prev_r <= 4'h0;
    end else begin
      s1_r <= raw_result;
      s2_r <= s1_r;
      prev_r <= adj;
    end
  end

  // event flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) evt_r <= 4'h0;
    else evt_r <= fire | (evt_r & ~evt_clr);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `NUM_CMP; i++) begin
        ctrl_r[i] <= `REG_RESET;
        msk_r[i] <= `REG_RESET;
      end
      idle_stop_r <= 1'b0;
    end else begin
      for (int i = 0; i < `NUM_CMP; i++) begin
        if (wr_go && avs_address == `OFS_CTRL1 + 6'(i * 4)) begin
          ctrl_r[i] <= merge(ctrl_r[i], avs_writedata, avs_byteenable,
                             (i == 3) ? `CTRL4_WMASK : `CTRL_WMASK);
        end
        if (wr_go && avs_address == `OFS_MSK1 + 6'(i * 4)) begin
          msk_r[i] <= merge(msk_r[i], avs_writedata, avs_byteenable, `MSK_WMASK);
        end
        // result bit tracks the live adjusted output and is not writable
        ctrl_r[i][`BIT_RES] <= adj[i];
        ctrl_r[i][`BIT_EVT] <= fire[i] | (evt_r[i] & ~evt_clr[i]);
      end
      // the alias register keeps its bit in byte lane 0, the status copy in lane 1
      if (wr_go && avs_address == `OFS_IDLE && avs_byteenable[0]) begin
        idle_stop_r <= avs_writedata[0];
      end
      if (wr_go && avs_address == `OFS_STATUS && avs_byteenable[1]) begin
        idle_stop_r <= avs_writedata[`BIT_STOP];
      end
    end
  end

endmodule : cmp_event_ctrl

// *** verification/cmp_core_model.sv ***
// behavioural analog comparator cores
// assumes the bench sets the level each running core reports
`timescale 1ns/1ps
module cmp_core_model (
  // clock
  input wire logic ref_clk,
  // from the block and bench
  input wire logic [3:0] core_enable,
  input wire logic [3:0] level,
  // results
  output logic [3:0] raw_result
);
  logic [3:0] churn_r = 4'h5;
  // a halted core has no defined output, so it churns
  always @(posedge ref_clk) churn_r <= ~churn_r;
  assign raw_result = (level & core_enable) | (churn_r & ~core_enable);
endmodule : cmp_core_model

// *** verification/cmp_event_ctrl_assertions.sv ***
// port checker for the comparator event control block
// assumes one clock domain and a bind onto every cmp_event_ctrl
`timescale 1ns/1ps
module cmp_event_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // bus
  input wire logic avs_read,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  // cores and events
  input wire logic [3:0] raw_result,
  input wire logic [3:0] core_enable,
  input wire logic [2:0] amplifier_mode_select,
  input wire logic [3:0] plus_sel_reference,
  input wire logic [3:0] plus_sel_pin,
  input wire logic [2:0] minus_sel_second,
  input wire logic [3:0] minus_sel_fourth,
  input wire logic [3:0] compare_output_pin,
  input wire logic [3:0] event_trigger,
  input wire logic [3:0] event_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic [4:0] hist_r;
  // loose window: the sync depth may differ by one without a false fire
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) hist_r <= 5'h00;
    else hist_r <= {hist_r[3:0], raw_result[0]};
  end
  sequence s_fire; event_trigger != 4'h0; endsequence
  sequence s_quiet; (event_trigger & $past(event_trigger)) == 4'h0; endsequence
  property p_pair; event_trigger == event_irq; endproperty
  property p_sticky; s_fire |=> s_quiet; endproperty
  // a polarity or enable change moves the adjusted output with a steady raw level
  property p_cause;
    event_trigger[0] |-> (hist_r != 5'h00 && hist_r != 5'h1F) || $changed(compare_output_pin[0]);
  endproperty
  property p_pin_off; (compare_output_pin & ~core_enable) == 4'h0; endproperty
  property p_plus; (plus_sel_reference & plus_sel_pin) == 4'h0; endproperty
  property p_amp_in; (amplifier_mode_select & (plus_sel_reference[2:0] | minus_sel_second)) == 3'h0; endproperty
  property p_amp_on; (amplifier_mode_select & ~core_enable[2:0]) == 3'h0; endproperty
  property p_fourth; $onehot(minus_sel_fourth); endproperty
  property p_upper; avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000; endproperty
  a_pair: assert property (p_pair) else $error("irq differs from trigger");
  a_sticky: assert property (p_sticky) else $error("event refired while flag set");
  a_cause: assert property (p_cause) else $error("event without output change");
  a_pin_off: assert property (p_pin_off) else $error("pin driven while off");
  a_plus: assert property (p_plus) else $error("two plus inputs selected");
  a_amp_in: assert property (p_amp_in) else $error("amp mode offers reference");
  a_amp_on: assert property (p_amp_on) else $error("amp mode while off");
  a_fourth: assert property (p_fourth) else $error("fourth minus not one-hot");
  a_upper: assert property (p_upper) else $error("upper read bits set");
endmodule : cmp_event_chk
bind cmp_event_ctrl cmp_event_chk u_chk (.ref_clk(ref_clk), .rstn(rstn), .avs_read(avs_read),
  .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .raw_result(raw_result),
  .core_enable(core_enable), .amplifier_mode_select(amplifier_mode_select),
  .plus_sel_reference(plus_sel_reference), .plus_sel_pin(plus_sel_pin), .minus_sel_second(minus_sel_second),
  .minus_sel_fourth(minus_sel_fourth), .compare_output_pin(compare_output_pin),
  .event_trigger(event_trigger), .event_irq(event_irq));

// *** verification/tb_cmp_event_ctrl.sv ***
// self-checking bench for cmp_event_ctrl
// assumes the core model and the bound checker
`timescale 1ns/1ps
`include "cmp_event_map.svh"
module tb_cmp_event_ctrl
  import cmp_event_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, adj, f, flag;
  logic device_idle = 1'b0;
  logic [3:0] level = 4'h0;
  logic [3:0] raw_result, core_enable, compare_output_pin, event_trigger, mask_a, mask_b, mask_c;
  logic [3:0] plus_sel_reference, plus_sel_pin, minus_sel_fourth;
  logic [2:0] amplifier_mode_select, minus_sel_first, minus_sel_second;
  mask_src_s mask_sources = '0;
  logic [15:0] seed = 16'h0023;
  logic [15:0] src, cfg;
  int n_fail = 0, n_checks = 0, n_trig = 0, base;
  cmp_event_ctrl dut (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .device_idle(device_idle), .raw_result(raw_result),
    .core_enable(core_enable), .amplifier_mode_select(amplifier_mode_select),
    .plus_sel_reference(plus_sel_reference), .plus_sel_pin(plus_sel_pin), .minus_sel_first(minus_sel_first),
    .minus_sel_second(minus_sel_second), .minus_sel_fourth(minus_sel_fourth), .compare_output_pin(compare_output_pin),
    .event_trigger(event_trigger), .event_irq(), .mask_sources(mask_sources), .mask_a(mask_a),
    .mask_b(mask_b), .mask_c(mask_c));
  cmp_core_model cores (.ref_clk(ref_clk), .core_enable(core_enable), .level(level), .raw_result(raw_result));
  initial forever #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (event_trigger[0] === 1'b1) n_trig <= n_trig + 1;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk1
  task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {16'h0000, d};
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    bus(1'b0, `OFS_CTRL1, 16'h0000);
    chk(q, 32'h00000000);
    bus(1'b0, 6'h28, 16'h0000);
    chk(q, 32'h00000000);
    bus(1'b1, `OFS_MSK1, 16'hFFFF);
    bus(1'b0, `OFS_MSK1, 16'h0000);
    chk(q, 32'h00000FFF);
    bus(1'b1, `OFS_CTRL2, 16'hFF3F);
    bus(1'b0, `OFS_CTRL2, 16'h0000);
    chk(q & 32'hFFFFFEFF, 32'h0000E413);
    chk1(amplifier_mode_select[1], 1'b1);
    chk1(plus_sel_reference[1] | plus_sel_pin[1], 1'b0);
    chk1(minus_sel_first[1] | minus_sel_second[1], 1'b0);
    bus(1'b1, `OFS_CTRL3, 16'h8001);
    bus(1'b1, `OFS_CTRL4, 16'h0412);
    @(posedge ref_clk);
    chk1(minus_sel_second[2], 1'b1);
    chk1(plus_sel_pin[2], 1'b1);
    chk(minus_sel_fourth, 32'h00000004);
    chk1(plus_sel_reference[3], 1'b1);
    bus(1'b0, `OFS_CTRL4, 16'h0000);
    chk(q, 32'h00000012);
    bus(1'b1, `OFS_CTRL1, 16'h8000);
    bus(1'b1, `OFS_STATUS, 16'h8000);
    device_idle <= 1'b1;
    @(posedge ref_clk);
    chk1(core_enable[0], 1'b0);
    device_idle <= 1'b0;
    @(posedge ref_clk);
    chk1(core_enable[0], 1'b1);
    chk1(compare_output_pin[0], 1'b0);
    for (int c = 0; c < 16; c++) begin
      seed = lfsr(seed);
      mask_sources <= seed[9:0];
      src = {seed[0], seed[1], seed[3], seed[2], 6'h00, seed[9:4]};
      bus(1'b1, `OFS_MSK1, {4'h0, c[3:0], c[3:0], c[3:0]});
      @(posedge ref_clk);
      chk1(mask_a[0], src[c]);
      chk1(mask_b[0], src[c]);
      chk1(mask_c[0], src[c]);
    end
    for (int k = 0; k < 8; k++) begin
      cfg = {2'h3, k[0], 5'h00, k[2:1], 6'h00};
      bus(1'b1, `OFS_CTRL1, cfg);
      repeat (8) @(posedge ref_clk);
      bus(1'b1, `OFS_CTRL1, cfg);
      @(posedge ref_clk);
      chk1(compare_output_pin[0], level[0] ^ k[0]);
      flag = 1'b0;
      for (int s = 0; s < 2; s++) begin
        base = n_trig;
        level[0] <= ~level[0];
        repeat (8) @(posedge ref_clk);
        adj = level[0] ^ k[0];
        f = !flag && (k[2:1] == 2'h3 || (k[2:1] == 2'h1 && adj) || (k[2:1] == 2'h2 && !adj));
        flag = flag | f;
        chk(n_trig - base, {31'h00000000, f});
        bus(1'b0, `OFS_STATUS, 16'h0000);
        chk1(q[8], flag);
        chk1(q[0], adj);
      end
    end
    // reset in mid-run must bring control 1 and the status register back to zero
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    bus(1'b0, `OFS_CTRL1, 16'h0000);
    chk(q, 32'h00000000);
    bus(1'b0, `OFS_STATUS, 16'h0000);
    chk(q, 32'h00000000);
    end_of_test();
  end
endmodule : tb_cmp_event_ctrl
